/* scg_pkg.sv */
/*
  shared constants for the system clock generator: register map, field
  positions, reset values, divider codes, timer lengths and state codes.
  assumes a one-clock design where mclk stands for the multiplied clock.
*/
package scg_pkg;
  localparam int REG_AW = 4;
  localparam int REG_DW = 8;
  localparam logic [3:0] OFS_CTRL0 = 4'h0;
  localparam logic [3:0] OFS_CTRL1 = 4'h4;
  localparam logic [3:0] OFS_CTRL2 = 4'h8;
  localparam logic [3:0] OFS_CTRL3 = 4'hc;
  // ctrl0: warm-up flag (read) / warm-up start (write), peripheral divide
  localparam int B_WARM = 0;
  localparam int B_PDIV = 4;
  // ctrl1: gear, oscillator divide select, peripheral source select
  localparam int B_GEAR = 0;
  localparam int B_OSC_DIVIDE_SELECT = 4;
  localparam int B_PERIPH_SOURCE_SELECT = 5;
  // ctrl2: warm-up select and source, drive reduce, oscillator enables
  localparam int B_WSEL = 0;
  localparam int B_WSRC = 2;
  localparam int B_HWEAK = 4;
  localparam int B_LWEAK = 5;
  localparam int B_HEN = 6;
  localparam int B_LEN = 7;
  // ctrl3: clock output select, lock time select, lock flag (read)
  localparam int B_CKSEL = 0;
  localparam int B_LSEL = 4;
  localparam int B_LFLAG = 7;
  localparam logic [1:0] GEAR_RST = 2'h3;
  localparam logic [1:0] PDIV_BY4 = 2'h0;
  localparam logic [1:0] PDIV_BY2 = 2'h1;
  localparam logic [1:0] PDIV_RST = PDIV_BY4;
  localparam logic [1:0] WSEL_RST = 2'h3;
  localparam logic [1:0] LSEL_RST = 2'h3;
  localparam logic [1:0] SEL_DIV4 = 2'h2;
  localparam logic [1:0] SEL_DIV2 = 2'h1;
  localparam logic [1:0] SEL_DIV1 = 2'h0;
  localparam int PLL_MULT = 4;
  localparam int TMR_W = 17;
  localparam logic [16:0] CYC_SEL0 = 17'h00004;
  localparam logic [16:0] CYC_SEL1 = 17'h00100;
  localparam logic [16:0] CYC_SEL2 = 17'h04000;
  localparam logic [16:0] CYC_SEL3 = 17'h10000;
  typedef enum logic [1:0] {
    TMR_IDLE = 2'b01,
    TMR_RUN = 2'b10
  } scg_tmr_type;
endpackage : scg_pkg

/* scg_div_if.sv */
/*
  carrier between the clock generator and its pulse dividers.
  assumes the user drives en_in and sel in the mclk domain.
*/
interface scg_div_if;
  logic en_in;
  logic [1:0] sel;
  logic en_out;
  modport div (input en_in, input sel, output en_out);
  modport user (output en_in, output sel, input en_out);
endinterface : scg_div_if

/* scg_pulse_div.sv */
/*
  divides a one-cycle enable pulse by 1, 2, 4 or 8 (two to the sel).
  assumes en_in is a pulse train in the mclk domain.
*/
module scg_pulse_div #(
  parameter int CNT_W = 3
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // pulse in, pulse out
  scg_div_if.div d
);
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [CNT_W-1:0] mask;
  logic wrap;

  if (CNT_W < 3) begin : g_chk
    $error("scg_pulse_div needs CNT_W of at least 3");
  end

  always_comb begin
    mask = CNT_W'((32'h1 << d.sel) - 32'h1);
    wrap = (cnt_r & mask) == mask;
    cnt_nxt = cnt_r;
    if (d.en_in) begin
      cnt_nxt = wrap ? '0 : CNT_W'(cnt_r + 1'b1);
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // combinational so that chained dividers stay aligned
  assign d.en_out = d.en_in & wrap;
endmodule : scg_pulse_div

/* scg_clock_gen.sv */
/*
  system clock generator: core source, gear and peripheral clocks as one-cycle
  enables, a toggled clock output pin, shared warm-up / lock-up timer, register port.
  assumes mclk stands for the multiplied clock, so the oscillator runs at
  mclk / 4; low_osc_tick is one pulse per low-speed clock cycle.
*/
// Added by the designer: the plain strobed port and the placing of the registers.
module scg_clock_gen #(
  parameter logic [16:0] WARM_CYC2 = scg_pkg::CYC_SEL2,
  parameter logic [16:0] WARM_CYC3 = scg_pkg::CYC_SEL3
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // pins and mode
  input wire logic pll_disable_strap_n,
  input wire logic low_osc_tick,
  input wire logic stop_mode,
  // oscillator control
  output logic high_osc_enable,
  output logic low_osc_enable,
  output logic high_osc_weak_drive,
  output logic low_osc_weak_drive,
  output logic pll_run,
  // clock enables and clock output
  output logic core_clk_en,
  output logic sys_clk_en,
  output logic periph_clk_en,
  output logic clock_output_pin
);
  if (WARM_CYC2 == 17'h0 || WARM_CYC3 == 17'h0) begin : g_chk
    $error("warm-up lengths must be non-zero");
  end

  scg_div_if half_if ();
  scg_div_if gear_if ();
  scg_div_if per_if ();

  // control registers
  logic [1:0] gear_r, gear_nxt, gear_act_r, gear_act_nxt;
  logic [1:0] pdiv_r, pdiv_nxt, wsel_r, wsel_nxt, lsel_r, lsel_nxt;
  logic osc_divide_select_r, osc_divide_select_nxt, periph_source_select_r, periph_source_select_nxt, wsrc_r, wsrc_nxt;
  logic hweak_r, hweak_nxt, lweak_r, lweak_nxt;
  logic hen_r, hen_nxt, len_r, len_nxt, cksel_r, cksel_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic sw_start;
  // timer state
  scg_pkg::scg_tmr_type st_r, st_nxt;
  logic [16:0] cnt_r, cnt_nxt, cnt_inc, warm_len, lock_len;
  logic warm_r, warm_nxt, lock_r, lock_nxt;
  logic pll_used_r, pll_used_nxt, cap_done_r, cap_done_nxt;
  logic start, tick, done;
  // clock path
  logic [1:0] osc_ph_r, osc_ph_nxt;
  logic osc_en, fc_en, lo_en;
  logic core_r, core_nxt, sys_r, sys_nxt, per_r, per_nxt;
  logic ck_r, ck_nxt, pll_run_r, pll_run_nxt;

  function automatic logic [16:0] sel_len(input logic [1:0] s);
    case (s)
      2'h0: sel_len = scg_pkg::CYC_SEL0;
      2'h1: sel_len = scg_pkg::CYC_SEL1;
      2'h2: sel_len = WARM_CYC2;
      default: sel_len = WARM_CYC3;
    endcase
  endfunction : sel_len

  // register file
  always_comb begin
    gear_nxt = gear_r;
    pdiv_nxt = pdiv_r;
    wsel_nxt = wsel_r;
    lsel_nxt = lsel_r;
    osc_divide_select_nxt = osc_divide_select_r;
    periph_source_select_nxt = periph_source_select_r;
    wsrc_nxt = wsrc_r;
    hweak_nxt = hweak_r;
    lweak_nxt = lweak_r;
    hen_nxt = hen_r;
    len_nxt = len_r;
    cksel_nxt = cksel_r;
    sw_start = 1'b0;
    rdata_nxt = 8'h00;
    if (reg_wr) begin
      case (reg_addr)
        scg_pkg::OFS_CTRL0: begin
          sw_start = reg_wdata[scg_pkg::B_WARM];
          pdiv_nxt = reg_wdata[scg_pkg::B_PDIV +: 2];
        end
        scg_pkg::OFS_CTRL1: begin
          gear_nxt = reg_wdata[scg_pkg::B_GEAR +: 2];
          osc_divide_select_nxt = reg_wdata[scg_pkg::B_OSC_DIVIDE_SELECT];
          periph_source_select_nxt = reg_wdata[scg_pkg::B_PERIPH_SOURCE_SELECT];
        end
        scg_pkg::OFS_CTRL2: begin
          wsel_nxt = reg_wdata[scg_pkg::B_WSEL +: 2];
          wsrc_nxt = reg_wdata[scg_pkg::B_WSRC];
          hweak_nxt = reg_wdata[scg_pkg::B_HWEAK];
          lweak_nxt = reg_wdata[scg_pkg::B_LWEAK];
          hen_nxt = reg_wdata[scg_pkg::B_HEN];
          len_nxt = reg_wdata[scg_pkg::B_LEN];
        end
        scg_pkg::OFS_CTRL3: begin
          cksel_nxt = reg_wdata[scg_pkg::B_CKSEL];
          lsel_nxt = reg_wdata[scg_pkg::B_LSEL +: 2];
        end
        default: begin
        end
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        scg_pkg::OFS_CTRL0: begin
          rdata_nxt[scg_pkg::B_WARM] = warm_r;
          rdata_nxt[scg_pkg::B_PDIV +: 2] = pdiv_r;
        end
        scg_pkg::OFS_CTRL1: begin
          rdata_nxt[scg_pkg::B_GEAR +: 2] = gear_r;
          rdata_nxt[scg_pkg::B_OSC_DIVIDE_SELECT] = osc_divide_select_r;
          rdata_nxt[scg_pkg::B_PERIPH_SOURCE_SELECT] = periph_source_select_r;
        end
        scg_pkg::OFS_CTRL2: begin
          rdata_nxt[scg_pkg::B_WSEL +: 2] = wsel_r;
          rdata_nxt[scg_pkg::B_WSRC] = wsrc_r;
          rdata_nxt[scg_pkg::B_HWEAK] = hweak_r;
          rdata_nxt[scg_pkg::B_LWEAK] = lweak_r;
          rdata_nxt[scg_pkg::B_HEN] = hen_r;
          rdata_nxt[scg_pkg::B_LEN] = len_r;
        end
        scg_pkg::OFS_CTRL3: begin
          rdata_nxt[scg_pkg::B_CKSEL] = cksel_r;
          rdata_nxt[scg_pkg::B_LSEL +: 2] = lsel_r;
          // undefined without the pll; reads 0 then
          rdata_nxt[scg_pkg::B_LFLAG] = lock_r & pll_used_r;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      gear_r <= scg_pkg::GEAR_RST;
      hen_r <= 1'b1;
      len_r <= 1'b0;
      osc_divide_select_r <= 1'b0;
      hweak_r <= 1'b0;
      lweak_r <= 1'b0;
      pdiv_r <= scg_pkg::PDIV_RST;
      periph_source_select_r <= 1'b0;
      lsel_r <= scg_pkg::LSEL_RST;
      wsel_r <= scg_pkg::WSEL_RST;
      wsrc_r <= 1'b0;
      cksel_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      gear_r <= gear_nxt;
      hen_r <= hen_nxt;
      len_r <= len_nxt;
      osc_divide_select_r <= osc_divide_select_nxt;
      hweak_r <= hweak_nxt;
      lweak_r <= lweak_nxt;
      pdiv_r <= pdiv_nxt;
      periph_source_select_r <= periph_source_select_nxt;
      lsel_r <= lsel_nxt;
      wsel_r <= wsel_nxt;
      wsrc_r <= wsrc_nxt;
      cksel_r <= cksel_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // shared warm-up / lock-up timer; strap caught one edge after release
  always_comb begin
    cap_done_nxt = 1'b1;
    pll_used_nxt = cap_done_r ? pll_used_r : pll_disable_strap_n;
    lo_en = len_r & low_osc_tick;
    osc_en = hen_r & (osc_ph_r == 2'(scg_pkg::PLL_MULT - 1));
    tick = wsrc_r ? lo_en : osc_en;
    start = sw_start | ~cap_done_r;
    warm_len = sel_len(wsel_r);
    lock_len = sel_len(lsel_r);
    cnt_inc = 17'(cnt_r + 1'b1);
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    warm_nxt = warm_r;
    lock_nxt = lock_r;
    done = 1'b0;
    case (st_r)
      scg_pkg::TMR_IDLE: begin
      end
      scg_pkg::TMR_RUN: begin
        if (tick) begin
          cnt_nxt = cnt_inc;
          if (cnt_inc >= warm_len) warm_nxt = 1'b0;
          if (cnt_inc >= lock_len) lock_nxt = 1'b0;
          done = ~warm_nxt & ~lock_nxt;
          if (done) st_nxt = scg_pkg::TMR_IDLE;
        end
      end
      default: st_nxt = scg_pkg::TMR_IDLE;
    endcase
    // a start beside completion restarts: the set wins
    if (start && (st_r != scg_pkg::TMR_RUN || done)) begin
      st_nxt = scg_pkg::TMR_RUN;
      cnt_nxt = 17'h0;
      warm_nxt = 1'b1;
      lock_nxt = pll_used_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st_r <= scg_pkg::TMR_IDLE;
      cnt_r <= 17'h0;
      warm_r <= 1'b0;
      lock_r <= 1'b1;
      pll_used_r <= 1'b0;
      cap_done_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      warm_r <= warm_nxt;
      lock_r <= lock_nxt;
      pll_used_r <= pll_used_nxt;
      cap_done_r <= cap_done_nxt;
    end
  end

  // clock path; mclk stands for the x4 pll output
  assign half_if.en_in = osc_en;
  assign half_if.sel = scg_pkg::SEL_DIV2;
  assign fc_en = pll_used_r ? hen_r
               : (osc_divide_select_r ? osc_en : half_if.en_out);
  assign gear_if.en_in = fc_en;
  assign gear_if.sel = gear_act_r;
  assign per_if.en_in = periph_source_select_r ? fc_en : gear_if.en_out;
  assign per_if.sel = (pdiv_r == scg_pkg::PDIV_BY4) ? scg_pkg::SEL_DIV4
                    : (pdiv_r == scg_pkg::PDIV_BY2) ? scg_pkg::SEL_DIV2
                    : scg_pkg::SEL_DIV1;

  scg_pulse_div u_half (.mclk(mclk), .reset(reset), .d(half_if.div));
  scg_pulse_div u_gear (.mclk(mclk), .reset(reset), .d(gear_if.div));
  scg_pulse_div u_per (.mclk(mclk), .reset(reset), .d(per_if.div));

  always_comb begin
    osc_ph_nxt = 2'(osc_ph_r + 1'b1);
    // new gear waits for the running period to end
    gear_act_nxt = gear_if.en_out ? gear_r : gear_act_r;
    core_nxt = fc_en;
    sys_nxt = gear_if.en_out;
    per_nxt = per_if.en_out;
    pll_run_nxt = pll_used_r & hen_r;
    ck_nxt = ck_r;
    // pin toggles, so it shows half the selected rate
    if (!stop_mode && (cksel_r ? gear_if.en_out : lo_en)) begin
      ck_nxt = ~ck_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      osc_ph_r <= 2'h0;
      gear_act_r <= scg_pkg::GEAR_RST;
      core_r <= 1'b0;
      sys_r <= 1'b0;
      per_r <= 1'b0;
      pll_run_r <= 1'b0;
      ck_r <= 1'b0;
    end else begin
      osc_ph_r <= osc_ph_nxt;
      gear_act_r <= gear_act_nxt;
      core_r <= core_nxt;
      sys_r <= sys_nxt;
      per_r <= per_nxt;
      pll_run_r <= pll_run_nxt;
      ck_r <= ck_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign high_osc_enable = hen_r;
  assign low_osc_enable = len_r;
  assign high_osc_weak_drive = hweak_r;
  assign low_osc_weak_drive = lweak_r;
  assign pll_run = pll_run_r;
  assign core_clk_en = core_r;
  assign sys_clk_en = sys_r;
  assign periph_clk_en = per_r;
  assign clock_output_pin = ck_r;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_reset_defaults: assert property ($past(reset) |-> gear_r == 2'h3
    && hen_r && !len_r) else $error("reset defaults wrong");
  a_pll_core_rate: assert property (pll_used_r && hen_r
    |-> fc_en ##1 fc_en) else $error("pll core source not full rate");
  a_pll_unused: assert property (!pll_used_r |-> !pll_run_r)
    else $error("pll runs while unused");
  a_osc_half: assert property (!pll_used_r && !osc_divide_select_r && fc_en
    |=> !half_if.en_out [*7]) else $error("core source not osc/2");
  a_warm_length: assert property ($rose(warm_r) && wsel_r == 2'h0
    && !wsrc_r |-> warm_r [*8] ##[1:12] !warm_r)
    else $error("short warm-up length wrong");
  a_warm_read: assert property (reg_rd && reg_addr == 4'h0
    |=> reg_rdata[0] == $past(warm_r)) else $error("warm flag read wrong");
  a_clkout_stop: assert property (stop_mode && $past(stop_mode)
    |-> $stable(clock_output_pin)) else $error("clock pin moves in stop");
  a_weak_reset: assert property ($past(reset)
    |-> !hweak_r && !lweak_r) else $error("drive reduce not cleared");
  a_periph_reset: assert property ($past(reset)
    |-> pdiv_r == 2'h0 && !periph_source_select_r) else $error("peripheral default wrong");
  a_lock_start: assert property ($rose(warm_r) && pll_used_r
    |-> lock_r) else $error("lock timing not started with warm-up");
  a_lock_unused: assert property (!pll_used_r && reg_rd
    && reg_addr == 4'hc |=> !reg_rdata[7]) else $error("lock flag leaks");
  a_gear_delay: assert property ($changed(gear_act_r)
    |-> $past(gear_if.en_out)) else $error("gear switched mid period");
  a_gear_ratio: assert property (gear_act_r == 2'h0
    |-> gear_if.en_out == fc_en) else $error("gear 00 not divide by one");

  c_warm_done: cover property ($fell(warm_r));
  c_lock_done: cover property (pll_used_r ##1 $fell(lock_r));
  c_gear_change: cover property ($changed(gear_act_r));
  c_clkout_sys: cover property (cksel_r && $changed(clock_output_pin));
endmodule : scg_clock_gen

/* scg_osc_model.sv */
/*
  low-speed oscillator beside the clock generator: one tick pulse per
  low-speed clock cycle while enabled, none if it was enabled with weak drive on.
  assumes enable and weak drive come from the clock generator in mclk.
*/
module scg_osc_model #(
  parameter int LOW_DIV = 10
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // oscillator control
  input wire logic low_osc_enable,
  input wire logic low_osc_weak_drive,
  // low-speed clock
  output logic low_osc_tick
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  logic en_q = 1'b0;
  // a resonator started on weak drive may never swing
  logic dead = 1'b0;
  always @(posedge mclk) begin
    en_q <= low_osc_enable;
    low_osc_tick <= 1'b0;
    if (reset || !low_osc_enable) begin
      cnt <= 0;
      dead <= 1'b0;
    end else if (!en_q && low_osc_weak_drive) begin
      dead <= 1'b1;
    end else if (!dead) begin
      cnt <= (cnt == LOW_DIV - 1) ? 0 : cnt + 1;
      low_osc_tick <= (cnt == LOW_DIV - 1);
    end
  end
endmodule : scg_osc_model

/* scg_clock_gen_bench.sv */
/*
  self-checking bench for the clock generator: register port tasks,
  clock period measurement, warm-up and lock timing, clock output pin.
  assumes small warm-up lengths 32 and 64 for the two long codes.
*/
module scg_clock_gen_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LOW_DIV = 10;
  localparam int WLEN [4] = '{4, 256, 32, 64};
  localparam int PDIV [3] = '{4, 2, 1};
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic strap_n = 1'b1;
  logic stop_mode = 1'b0;
  logic [7:0] reg_rdata;
  logic low_tick, high_en, low_en, high_weak, low_weak, pll_run;
  logic core_en, sys_en, per_en, clk_pin;
  logic prev_pin = 1'b0;
  int fails = 0;
  int checks_done = 0;
  int cyc = 0;

  scg_clock_gen #(.WARM_CYC2(17'h00020), .WARM_CYC3(17'h00040))
  u_scg_clock_gen (
    .mclk(mclk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pll_disable_strap_n(strap_n),
    .low_osc_tick(low_tick), .stop_mode(stop_mode),
    .high_osc_enable(high_en), .low_osc_enable(low_en),
    .high_osc_weak_drive(high_weak), .low_osc_weak_drive(low_weak),
    .pll_run(pll_run), .core_clk_en(core_en), .sys_clk_en(sys_en),
    .periph_clk_en(per_en), .clock_output_pin(clk_pin)
  );
  scg_osc_model #(.LOW_DIV(LOW_DIV)) u_scg_osc_model (
    .mclk(mclk), .reset(reset), .low_osc_enable(low_en),
    .low_osc_weak_drive(low_weak), .low_osc_tick(low_tick)
  );

  always #25 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    prev_pin <= clk_pin;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string msg);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %0h", $time, msg, got);
    end
  endtask : chk

  task automatic chk_rng(input int got, input int lo, input int hi,
                         input string msg);
    checks_done++;
    if (got < lo || got > hi) begin
      fails++;
      $display("unexpected at %0t: %s took %0d", $time, msg, got);
    end
  endtask : chk_rng

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rd

  function automatic logic pick(input int w);
    case (w)
      0: return core_en;
      1: return sys_en;
      2: return per_en;
      default: return clk_pin ^ prev_pin;
    endcase
  endfunction : pick

  // cycles between two pulses of the chosen enable (or pin toggles)
  task automatic measure(input int w, output int per);
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (pick(w) !== 1'b1 && n < 300);
    per = 0;
    do begin
      @(posedge mclk);
      #1;
      per++;
    end while (pick(w) !== 1'b1 && per < 300);
    if (n >= 300 || per >= 300) begin
      fails++;
      $display("unexpected at %0t: no pulse", $time);
      report_and_stop();
    end
  endtask : measure

  task automatic poll(input logic [3:0] a, input int b, output logic first,
                      output int took);
    logic [7:0] d;
    int n;
    int t0;
    t0 = cyc;
    n = 0;
    rd(a, d);
    first = d[b];
    while (d[b] !== 1'b0 && n < 3000) begin
      rd(a, d);
      n++;
    end
    took = cyc - t0;
    if (n >= 3000) begin
      fails++;
      $display("unexpected at %0t: flag stuck", $time);
      report_and_stop();
    end
  endtask : poll

  task automatic do_reset(input logic s);
    @(posedge mclk);
    reset <= 1'b1;
    strap_n <= s;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
  endtask : do_reset

  initial begin
    logic [7:0] d;
    logic f;
    int t;
    int p;
    int n;
    do_reset(1'b1);
    rd(scg_pkg::OFS_CTRL0, d);
    chk(d & 8'h31, 8'h01, "ctrl0 reset");
    rd(scg_pkg::OFS_CTRL1, d);
    chk(d & 8'h33, 8'h03, "ctrl1 reset");
    rd(scg_pkg::OFS_CTRL2, d);
    chk(d & 8'hf7, 8'h43, "ctrl2 reset");
    rd(scg_pkg::OFS_CTRL3, d);
    chk(d & 8'hb1, 8'hb0, "ctrl3 reset");
    rd(4'h2, d);
    chk(d, 8'h00, "unmapped read");
    chk({high_en, low_en, high_weak, low_weak, pll_run}, 5'h11,
        "pins");
    poll(scg_pkg::OFS_CTRL3, 7, f, t);
    chk(f, 1'b1, "lock flag set");
    chk_rng(t, 224, 264, "default lock");
    $display("test reset_and_lock done");
    for (int c = 0; c < 4; c++) begin
      wr(scg_pkg::OFS_CTRL3, 8'(c << 4));
      wr(scg_pkg::OFS_CTRL2, 8'(8'h40 | c));
      wr(scg_pkg::OFS_CTRL0, 8'h01);
      poll(scg_pkg::OFS_CTRL0, 0, f, t);
      chk(f, 1'b1, "warm started");
      chk_rng(t, WLEN[c] * 4 - 4, WLEN[c] * 4 + 12, "warm");
      poll(scg_pkg::OFS_CTRL3, 7, f, t);
      chk_rng(t, 0, 16, "lock after warm");
    end
    $display("test warmup done");
    measure(0, p);
    chk(16'(p), 16'h1, "core pll");
    for (int g = 3; g >= 0; g--) begin
      wr(scg_pkg::OFS_CTRL1, 8'(g));
      repeat (20) @(posedge mclk);
      measure(1, p);
      chk(16'(p), 16'(1 << g), "gear");
    end
    for (int s = 0; s < 2; s++) begin
      wr(scg_pkg::OFS_CTRL1, s ? 8'h21 : 8'h01);
      for (int k = 0; k < 3; k++) begin
        wr(scg_pkg::OFS_CTRL0, 8'(k << 4));
        repeat (40) @(posedge mclk);
        measure(2, p);
        chk(16'(p), 16'(PDIV[k] * (2 - s)), "periph");
      end
    end
    $display("test rates done");
    wr(scg_pkg::OFS_CTRL1, 8'h00);
    wr(scg_pkg::OFS_CTRL3, 8'h31);
    repeat (4) @(posedge mclk);
    measure(3, p);
    chk(16'(p), 16'h1, "pin system");
    // weak drive stays off while the low oscillator starts
    wr(scg_pkg::OFS_CTRL2, 8'hc3);
    wr(scg_pkg::OFS_CTRL3, 8'h30);
    repeat (30) @(posedge mclk);
    measure(3, p);
    chk(16'(p), 16'(LOW_DIV), "pin low speed");
    // shortest low-speed warm-up before standby; lock keeps timer busy
    wr(scg_pkg::OFS_CTRL2, 8'hc4);
    wr(scg_pkg::OFS_CTRL0, 8'h01);
    poll(scg_pkg::OFS_CTRL0, 0, f, t);
    chk(f, 1'b1, "low warm started");
    chk_rng(t, 30, 46, "warm low speed");
    @(posedge mclk);
    stop_mode <= 1'b1;
    repeat (2) @(posedge mclk);
    n = 0;
    repeat (40) begin
      @(posedge mclk);
      #1;
      if (pick(3) === 1'b1) n++;
    end
    chk(16'(n), 16'h0, "pin frozen");
    @(posedge mclk);
    stop_mode <= 1'b0;
    wr(scg_pkg::OFS_CTRL2, 8'hf3);
    #1;
    chk({high_weak, low_weak}, 2'h3, "weak on");
    wr(scg_pkg::OFS_CTRL2, 8'hc3);
    #1;
    chk({high_weak, low_weak}, 2'h0, "weak off");
    $display("test pin_and_drive done");
    do_reset(1'b0);
    #1;
    chk(pll_run, 1'b0, "pll unused");
    rd(scg_pkg::OFS_CTRL3, d);
    chk(d & 8'h80, 8'h00, "lock flag unused");
    measure(0, p);
    chk(16'(p), 16'h8, "core osc/2");
    wr(scg_pkg::OFS_CTRL1, 8'h10);
    repeat (80) @(posedge mclk);
    measure(0, p);
    chk(16'(p), 16'h4, "core osc");
    measure(1, p);
    chk(16'(p), 16'h4, "sys gear 00");
    $display("test strap_low done");
    report_and_stop();
  end
endmodule : scg_clock_gen_bench
